/* pkg/fcd_map.svh */
// offsets, field positions and clock rate of the dma controller
`ifndef FCD_MAP_SVH
`define FCD_MAP_SVH
`define FCD_CHANNELS        4
`define FCD_MSG_WORDS       8
`define FCD_FIFO_DEPTH      32
`define FCD_WORD_W          16
`define FCD_ADDR_W          24
// command word 0 fields
`define FCD_W0_TYPE_LSB     0
`define FCD_W0_WIDE_BIT     2
`define FCD_W0_SAME_BIT     3
`define FCD_W0_CHAN_LSB     4
`define FCD_W0_DEV_LSB      6
`define FCD_W0_SINGLE_BIT   8
`define FCD_W0_ABORT_BIT    12
// status word codes
`define FCD_ST_DONE         4'h1
`define FCD_ST_ABORT        4'h2
`define FCD_ST_REJECT       4'h3
// clock rate
`define FCD_CLK_MHZ         250
`endif

/* pkg/fcd_pkg.sv */
// types of the four channel dma controller
package fcd_pkg;
  typedef enum logic [1:0]
  {
    FCD_M2M = 2'b00,
    FCD_M2D = 2'b01,
    FCD_D2M = 2'b10,
    FCD_D2D = 2'b11
  } fcd_xtype_e;

  typedef enum logic [2:0]
  {
    FCD_SLAVE  = 3'b000,
    FCD_REQ    = 3'b001,
    FCD_FLY    = 3'b010,
    FCD_RD     = 3'b011,
    FCD_WR     = 3'b100,
    FCD_REPORT = 3'b101
  } fcd_state_e;

  typedef struct packed
  {
    logic        active;
    fcd_xtype_e  xtype;
    logic        wide;
    logic        same_lane;
    logic        single;
    logic [1:0]  dev_src;
    logic [1:0]  dev_dst;
    logic [23:0] src;
    logic [23:0] dst;
    logic [15:0] count;
    logic [7:0]  ident;
  } fcd_chan_s;
endpackage

/* pkg/fcd_stream_if.sv */
// valid/ready word stream between the controller's own modules
`timescale 1ns/10ps
interface fcd_stream_if;
  logic        valid;
  logic        ready;
  logic [15:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* rtl/fcd_fifo.sv */
// command fifo with parameterised width and depth
`timescale 1ns/10ps
`include "fcd_map.svh"
module fcd_fifo #(
  parameter int WIDTH = `FCD_WORD_W,
  parameter int DEPTH = `FCD_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic reset_n,
  // streams
  fcd_stream_if.snk in_s,
  fcd_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;

  assign in_s.ready  = (cnt_r != DEPTH[AW:0]);
  assign out_s.valid = (cnt_r != '0);
  assign out_s.data  = mem_r[rp_r];
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  always_comb
  begin
    wp_nxt  = push ? wp_r + 1'b1 : wp_r;
    rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (push)
      mem_r[wp_r] <= in_s.data;
  end
endmodule

/* rtl/fcd_addr_step.sv */
// next address and count of one transfer step
`timescale 1ns/10ps
module fcd_addr_step (
  // current values
  input  wire logic [23:0] addr,
  input  wire logic [15:0] count,
  input  wire logic        wide,
  input  wire logic        fixed,
  // results
  output logic [23:0]      addr_next,
  output logic [15:0]      count_next,
  output logic             last
);
  // devices have no address, so theirs stays fixed
  assign addr_next  = fixed ? addr : addr + (wide ? 24'h000002 : 24'h000001);
  assign count_next = count - 16'h0001;
  assign last       = (count == 16'h0001);
endmodule

/* rtl/fcd_dma.sv */
// four channel dma controller top
//
// Contract
// - four independent channels, each any transfer type
// - after reset stay slave, bus undriven, until a message arrives
// - ready transfer requests bus; on grant drive address, data, strobes
// - end, preemption or abort ends transfer, frees bus, back to slave
// - each cycle test count, make strobes, compute next address together
// - fly-by only for memory and device on same data lanes
// - fly-by starts only after peripheral request asserted
// - fly-by drives memory address, read to source, write to destination
// - fly-by asserts device acknowledge as its chip select
// - fly-by operand passes directly in one bus cycle
// - fly-by moves one word per cycle with ready targets
// - double cycle for memory-memory, device-device, mismatched lanes
// - memory copies use separate source and destination addresses
// - double cycle reads, holds operand, then writes it
// - low ready stretches the bus cycle until ready high
// - memory copies self-request continuously, back to back
// - single mode: one request per operand, low between
// - device transfers wait for external request
// - bus request active low; master only after grant low
// - lost grant releases bus; re-request while work pending
// - report puts status word out, goes slave, raises interrupt
`timescale 1ns/10ps
`include "fcd_map.svh"
module fcd_dma (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // host command write port
  input  wire logic        cmd_valid,
  input  wire logic [15:0] cmd_data,
  output logic             cmd_ready,
  input  wire logic        status_ack,
  output logic [15:0]      status_output_register,
  output logic             host_interrupt,
  // arbiter
  output logic             bus_request_n,
  input  wire logic        bus_grant_n,
  output logic             bus_master,
  // system bus
  output logic [23:0]      addr_out,
  output logic             addr_oe,
  input  wire logic [15:0] data_in,
  output logic [15:0]      data_out,
  output logic             data_oe,
  output logic             rd_n,
  output logic             wr_n,
  output logic             word_n,
  input  wire logic        ready,
  // peripherals
  input  wire logic [3:0]  transfer_request,
  output logic [3:0]       transfer_acknowledge_n,
  input  wire logic        hw_abort
);
  fcd_stream_if cin();
  fcd_stream_if cout();

  assign cin.valid = cmd_valid;
  assign cin.data  = cmd_data;
  assign cmd_ready = cin.ready;

  fcd_fifo #(.WIDTH(`FCD_WORD_W), .DEPTH(`FCD_FIFO_DEPTH)) u_fifo (
    .mclk    (mclk),
    .reset_n (reset_n),
    .in_s    (cin),
    .out_s   (cout)
  );

  // =========================================
  // message assembly
  logic [15:0]        msg_r [8];
  logic [2:0]         widx_r, widx_nxt;
  logic               msg_done;
  fcd_pkg::fcd_chan_s ch_r [4];
  fcd_pkg::fcd_chan_s ch_nxt [4];
  fcd_pkg::fcd_state_e st_r, st_nxt;
  logic [1:0]         cur_r, cur_nxt;
  logic [15:0]        hold_r, hold_nxt;
  logic [15:0]        stat_r, stat_nxt;
  logic               irq_r, irq_nxt;
  logic               pend_r, pend_nxt;

  // message only drained while not mid-transfer, so the fifo backs up
  assign cout.ready = (st_r == fcd_pkg::FCD_SLAVE) && !pend_r;
  assign msg_done   = cout.valid && cout.ready && (widx_r == 3'h7);

  always_comb
  begin
    widx_nxt = (cout.valid && cout.ready) ? widx_r + 3'h1 : widx_r;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      widx_r <= 3'h0;
    else
      widx_r <= widx_nxt;
  end

  always_ff @(posedge mclk)
  begin
    if (cout.valid && cout.ready)
      msg_r[widx_r] <= cout.data;
  end

  // =========================================
  // channel selection
  logic [3:0] want;
  logic       any_want;
  logic [1:0] pick;
  fcd_pkg::fcd_chan_s cc;
  logic       is_dev_src, is_dev_dst, fly;
  logic [1:0] dev;

  always_comb
  begin
    want = 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      case (ch_r[i].xtype)
        fcd_pkg::FCD_M2M: want[i] = ch_r[i].active;
        fcd_pkg::FCD_D2M, fcd_pkg::FCD_D2D: want[i] = ch_r[i].active && transfer_request[ch_r[i].dev_src];
        default: want[i] = ch_r[i].active && transfer_request[ch_r[i].dev_dst];
      endcase
    end
  end

  // lower channel number wins
  always_comb
  begin
    pick = 2'h0;
    for (int i = 3; i >= 0; i--)
    begin
      if (want[i])
        pick = i[1:0];
    end
  end
  assign any_want = |want;

  assign cc         = ch_r[cur_r];
  assign is_dev_src = (cc.xtype == fcd_pkg::FCD_D2M) || (cc.xtype == fcd_pkg::FCD_D2D);
  assign is_dev_dst = (cc.xtype == fcd_pkg::FCD_M2D) || (cc.xtype == fcd_pkg::FCD_D2D);
  // fly-by needs exactly one device and shared lanes
  assign fly        = (is_dev_src ^ is_dev_dst) && cc.same_lane;
  assign dev        = is_dev_src ? cc.dev_src : cc.dev_dst;

  logic [23:0] sa_n, da_n;
  logic [15:0] cnt_n;
  logic        last;

  fcd_addr_step u_src_step (
    .addr       (cc.src),
    .count      (cc.count),
    .wide       (cc.wide),
    .fixed      (is_dev_src),
    .addr_next  (sa_n),
    .count_next (cnt_n),
    .last       (last)
  );

  fcd_addr_step u_dst_step (
    .addr       (cc.dst),
    .count      (cc.count),
    .wide       (cc.wide),
    .fixed      (is_dev_dst),
    .addr_next  (da_n),
    .count_next (),
    .last       ()
  );

  // =========================================
  // transfer sequencer
  logic still_req;
  assign still_req = is_dev_src ? transfer_request[cc.dev_src] :
                     is_dev_dst ? transfer_request[cc.dev_dst] : 1'b1;

  always_comb
  begin
    st_nxt   = st_r;
    cur_nxt  = cur_r;
    hold_nxt = hold_r;
    stat_nxt = stat_r;
    irq_nxt  = irq_r && !status_ack;
    pend_nxt = pend_r;
    for (int i = 0; i < 4; i++)
      ch_nxt[i] = ch_r[i];
    case (st_r)
      fcd_pkg::FCD_SLAVE:
      begin
        if (msg_done)
        begin
          if (msg_r[0][`FCD_W0_ABORT_BIT])
            ch_nxt[msg_r[0][`FCD_W0_CHAN_LSB +: 2]].active = 1'b0;
          else if (msg_r[6] == 16'h0000)
          begin
            stat_nxt = {`FCD_ST_REJECT, 4'h0, cout.data[7:0]};
            irq_nxt  = 1'b1;
          end
          else
          begin
            ch_nxt[msg_r[0][`FCD_W0_CHAN_LSB +: 2]] = '{
              active:    1'b1,
              xtype:     fcd_pkg::fcd_xtype_e'(msg_r[0][`FCD_W0_TYPE_LSB +: 2]),
              wide:      msg_r[0][`FCD_W0_WIDE_BIT] && !msg_r[1][0] && !msg_r[3][0],
              same_lane: msg_r[0][`FCD_W0_SAME_BIT],
              single:    msg_r[0][`FCD_W0_SINGLE_BIT],
              dev_src:   msg_r[0][`FCD_W0_DEV_LSB +: 2],
              dev_dst:   msg_r[0][`FCD_W0_DEV_LSB + 2 +: 2],
              src:       {msg_r[2][7:0], msg_r[1]},
              dst:       {msg_r[4][7:0], msg_r[3]},
              count:     msg_r[6],
              ident:     cout.data[7:0]};
          end
        end
        else if (any_want)
        begin
          cur_nxt = pick;
          st_nxt  = fcd_pkg::FCD_REQ;
        end
        pend_nxt = 1'b0;
      end
      fcd_pkg::FCD_REQ:
      begin
        if (!bus_grant_n)
          st_nxt = fly ? fcd_pkg::FCD_FLY : fcd_pkg::FCD_RD;
      end
      fcd_pkg::FCD_FLY, fcd_pkg::FCD_RD, fcd_pkg::FCD_WR:
      begin
        if (hw_abort)
        begin
          ch_nxt[cur_r].active = 1'b0;
          stat_nxt = {`FCD_ST_ABORT, 4'h0, cc.ident};
          irq_nxt  = 1'b1;
          st_nxt   = fcd_pkg::FCD_SLAVE;
        end
        else if (bus_grant_n)
        begin
          pend_nxt = 1'b1;
          st_nxt   = fcd_pkg::FCD_SLAVE;
        end
        else if (ready && (st_r == fcd_pkg::FCD_RD))
        begin
          hold_nxt = data_in;
          st_nxt   = fcd_pkg::FCD_WR;
        end
        else if (ready)
        begin
          ch_nxt[cur_r].src   = sa_n;
          ch_nxt[cur_r].dst   = da_n;
          ch_nxt[cur_r].count = cnt_n;
          if (last)
          begin
            ch_nxt[cur_r].active = 1'b0;
            stat_nxt = {`FCD_ST_DONE, 4'h0, cc.ident};
            irq_nxt  = 1'b1;
            st_nxt   = fcd_pkg::FCD_SLAVE;
          end
          else if (any_want && (pick < cur_r))
            st_nxt = fcd_pkg::FCD_SLAVE;
          else if (cc.single || !still_req)
            st_nxt = fcd_pkg::FCD_SLAVE;
          else
            st_nxt = fly ? fcd_pkg::FCD_FLY : fcd_pkg::FCD_RD;
        end
      end
      default: st_nxt = fcd_pkg::FCD_SLAVE;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r   <= fcd_pkg::FCD_SLAVE;
      cur_r  <= 2'h0;
      hold_r <= 16'h0000;
      stat_r <= 16'h0000;
      irq_r  <= 1'b0;
      pend_r <= 1'b0;
      for (int i = 0; i < 4; i++)
        ch_r[i] <= '0;
    end
    else
    begin
      st_r   <= st_nxt;
      cur_r  <= cur_nxt;
      hold_r <= hold_nxt;
      stat_r <= stat_nxt;
      irq_r  <= irq_nxt;
      pend_r <= pend_nxt;
      for (int i = 0; i < 4; i++)
        ch_r[i] <= ch_nxt[i];
    end
  end

  // =========================================
  // bus outputs; all held by state while ready is low
  logic active_bus;
  assign active_bus = (st_r == fcd_pkg::FCD_FLY) || (st_r == fcd_pkg::FCD_RD) || (st_r == fcd_pkg::FCD_WR);

  assign bus_request_n = (st_r != fcd_pkg::FCD_REQ);
  assign bus_master    = active_bus;
  assign addr_oe       = active_bus && !(st_r == fcd_pkg::FCD_RD ? is_dev_src : (st_r == fcd_pkg::FCD_WR && is_dev_dst));
  assign addr_out      = (st_r == fcd_pkg::FCD_WR || (st_r == fcd_pkg::FCD_FLY && is_dev_src)) ? cc.dst : cc.src;
  assign rd_n          = !(st_r == fcd_pkg::FCD_FLY || st_r == fcd_pkg::FCD_RD);
  assign wr_n          = !(st_r == fcd_pkg::FCD_FLY || st_r == fcd_pkg::FCD_WR);
  assign data_oe       = (st_r == fcd_pkg::FCD_WR);
  assign data_out      = hold_r;
  assign word_n        = !(active_bus && cc.wide);
  assign status_output_register = stat_r;
  assign host_interrupt = irq_r;

  always_comb
  begin
    transfer_acknowledge_n = 4'hF;
    if (st_r == fcd_pkg::FCD_FLY)
      transfer_acknowledge_n[dev] = 1'b0;
    else if (st_r == fcd_pkg::FCD_RD && is_dev_src)
      transfer_acknowledge_n[cc.dev_src] = 1'b0;
    else if (st_r == fcd_pkg::FCD_WR && is_dev_dst)
      transfer_acknowledge_n[cc.dev_dst] = 1'b0;
  end

  // =========================================
  // checks
  property p_req_before_master;
    @(posedge mclk) disable iff (!reset_n)
      $rose(bus_master) |-> $past(!bus_grant_n) && $past(!bus_request_n);
  endproperty
  a_req_before_master: assert property (p_req_before_master) else $error("master without grant");

  property p_slave_idle;
    @(posedge mclk) disable iff (!reset_n)
      !bus_master |-> rd_n && wr_n && !addr_oe && !data_oe && (transfer_acknowledge_n == 4'hF);
  endproperty
  a_slave_idle: assert property (p_slave_idle) else $error("bus driven in slave mode");

  property p_wait_holds;
    @(posedge mclk) disable iff (!reset_n)
      bus_master && !ready && !bus_grant_n && !hw_abort |=> $stable(addr_out) && $stable(rd_n) && $stable(wr_n);
  endproperty
  a_wait_holds: assert property (p_wait_holds) else $error("bus moved while not ready");

  property p_fly_ack;
    @(posedge mclk) disable iff (!reset_n)
      (st_r == fcd_pkg::FCD_FLY) |-> !rd_n && !wr_n && (transfer_acknowledge_n != 4'hF);
  endproperty
  a_fly_ack: assert property (p_fly_ack) else $error("fly-by without strobes or ack");

  property p_rd_then_wr;
    @(posedge mclk) disable iff (!reset_n)
      (st_r == fcd_pkg::FCD_RD) && ready && !bus_grant_n && !hw_abort |=> (st_r == fcd_pkg::FCD_WR) && data_oe;
  endproperty
  a_rd_then_wr: assert property (p_rd_then_wr) else $error("read not followed by write");

  property p_lost_grant;
    @(posedge mclk) disable iff (!reset_n)
      bus_master && bus_grant_n |=> !bus_master;
  endproperty
  a_lost_grant: assert property (p_lost_grant) else $error("bus kept after grant withdrawn");

  property p_done_irq;
    @(posedge mclk) disable iff (!reset_n)
      bus_master && ready && last && (st_r != fcd_pkg::FCD_RD) && !bus_grant_n && !hw_abort |=> host_interrupt && !bus_master;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("completion not reported");

  property p_fly_needs_lanes;
    @(posedge mclk) disable iff (!reset_n)
      (st_r == fcd_pkg::FCD_FLY) |-> cc.same_lane && (is_dev_src != is_dev_dst);
  endproperty
  a_fly_needs_lanes: assert property (p_fly_needs_lanes) else $error("illegal fly-by");

  c_fly: cover property (@(posedge mclk) disable iff (!reset_n) (st_r == fcd_pkg::FCD_FLY) ##1 (st_r == fcd_pkg::FCD_FLY));
  c_dbl: cover property (@(posedge mclk) disable iff (!reset_n) (st_r == fcd_pkg::FCD_RD) ##1 (st_r == fcd_pkg::FCD_WR));
  c_irq: cover property (@(posedge mclk) disable iff (!reset_n) $rose(host_interrupt));
endmodule

/* sim/fcd_bus_model.sv */
// far side model: bus arbiter, word memory and peripheral devices
`timescale 1ns/10ps
module fcd_bus_model (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // bench controls
  input  wire logic [1:0]  waits,
  input  wire logic        yield,
  input  wire logic        dev_is_src,
  // controller side of the bus
  input  wire logic        bus_request_n,
  input  wire logic        bus_master,
  input  wire logic [23:0] addr_out,
  input  wire logic        addr_oe,
  input  wire logic [15:0] data_out,
  input  wire logic        data_oe,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [3:0]  ack_n,
  // answers
  output logic             bus_grant_n,
  output logic             ready,
  output logic [15:0]      data_in,
  output logic [7:0]       dev_cnt,
  output logic [15:0]      dev_last
);
  logic [15:0] mem [0:511];
  logic [1:0]  wait_r;
  logic [15:0] last_r;
  logic [15:0] bus;
  logic        dev_sel;
  // ====================================
  // decoder, data lines
  assign dev_sel = ~&ack_n;
  // slow targets hold ready low for the chosen wait states
  assign ready = (~rd_n | ~wr_n) && wait_r == waits;
  always_comb
  begin
    if (dev_sel && dev_is_src)
      data_in = 16'hD000 | {8'h00, dev_cnt};
    else if (addr_oe && !rd_n)
      data_in = mem[addr_out[9:1]];
    else
      data_in = ~last_r; // released lines must not look driven
  end
  assign bus = data_oe ? data_out : data_in;
  // ====================================
  // arbiter, wait states, devices
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wait_r <= 2'h0;
      bus_grant_n <= 1'b1;
      last_r <= 16'h0000;
      dev_cnt <= 8'h00;
      dev_last <= 16'h0000;
    end
    else
    begin
      bus_grant_n <= !((!bus_request_n || bus_master) && !yield);
      wait_r <= (ready || (rd_n && wr_n)) ? 2'h0 : wait_r + 2'h1;
      last_r <= data_in;
      if (dev_sel && ready && (dev_is_src ? !rd_n : !wr_n))
      begin
        dev_cnt <= dev_cnt + 8'h01;
        dev_last <= bus;
      end
    end
  end
  always @(posedge mclk)
  begin
    if (addr_oe && !wr_n && ready && (!dev_sel || dev_is_src))
      mem[addr_out[9:1]] <= bus;
  end
endmodule

/* sim/tb_four_channel_dma_controller.sv */
// self-checking bench of the four channel dma controller
`timescale 1ns/10ps
module tb_four_channel_dma_controller;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic        cmd_valid = 1'b0;
  logic [15:0] cmd_data = 16'h0000;
  logic        status_ack = 1'b0;
  logic        hw_abort = 1'b0;
  logic [3:0]  transfer_request = 4'h0;
  logic [1:0]  waits = 2'h0;
  logic        yield = 1'b0;
  logic        dev_is_src = 1'b0;
  logic        cmd_ready, host_interrupt, bus_request_n, bus_grant_n, bus_master;
  logic        addr_oe, data_oe, rd_n, wr_n, word_n, ready;
  logic [15:0] status_output_register, data_in, data_out, dev_last;
  logic [23:0] addr_out;
  logic [3:0]  transfer_acknowledge_n;
  logic [7:0]  dev_cnt;
  int          num_errors = 0;
  int          checked = 0;
  int          mcyc;
  always #2 mclk = ~mclk;
  fcd_dma i_dut (.mclk, .reset_n, .cmd_valid, .cmd_data, .cmd_ready, .status_ack, .status_output_register,
    .host_interrupt, .bus_request_n, .bus_grant_n, .bus_master, .addr_out, .addr_oe, .data_in, .data_out,
    .data_oe, .rd_n, .wr_n, .word_n, .ready, .transfer_request, .transfer_acknowledge_n, .hw_abort);
  fcd_bus_model i_bus (.mclk, .reset_n, .waits, .yield, .dev_is_src, .bus_request_n, .bus_master, .addr_out,
    .addr_oe, .data_out, .data_oe, .rd_n, .wr_n, .ack_n(transfer_acknowledge_n), .bus_grant_n, .ready,
    .data_in, .dev_cnt, .dev_last);
  // ====================================
  // shared tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_up();
    num_errors++;
    $display("CHECK FAILED at %0t wait limit got %h exp %h", $time, 1'b0, 1'b1);
    summarize();
  endtask
  task automatic send(input logic [15:0] w0, input logic [23:0] src, input logic [23:0] dst,
                      input logic [15:0] cnt, input logic [7:0] id);
    logic [15:0] w [8];
    int          n;
    w = '{w0, src[15:0], {8'h00, src[23:16]}, dst[15:0], {8'h00, dst[23:16]}, 16'h0000, cnt, {8'h00, id}};
    @(posedge mclk);
    for (int i = 0; i < 8; i++)
    begin
      cmd_valid <= 1'b1;
      cmd_data <= w[i];
      n = 0;
      @(negedge mclk);
      while (cmd_ready !== 1'b1 && n < 100)
      begin
        @(negedge mclk);
        n++;
      end
      if (n == 100)
        give_up();
      @(posedge mclk);
    end
    cmd_valid <= 1'b0;
  endtask
  task automatic wait_master();
    int n;
    n = 0;
    while (bus_master !== 1'b1 && n < 200)
    begin
      @(negedge mclk);
      n++;
    end
    if (n == 200)
      give_up();
  endtask
  // waits for the report, counting master cycles on the way
  task automatic finish_op(input logic [3:0] code, input logic [7:0] id);
    int n;
    n = 0;
    while (host_interrupt !== 1'b1 && n < 2000)
    begin
      @(negedge mclk);
      n++;
      if (bus_master === 1'b1)
        mcyc++;
    end
    if (n == 2000)
      give_up();
    chk(status_output_register, {code, 4'h0, id});
    @(posedge mclk);
    status_ack <= 1'b1;
    @(posedge mclk);
    status_ack <= 1'b0;
    @(negedge mclk);
    chk(host_interrupt, 1'b0);
    chk({bus_master, bus_request_n, transfer_acknowledge_n}, 6'h1F);
  endtask
  // ====================================
  // scenarios
  task automatic t_reset();
    chk({bus_request_n, bus_master, host_interrupt, addr_oe, data_oe}, 5'h10);
    chk(transfer_acknowledge_n, 4'hF);
    $display("test reset done");
  endtask
  task automatic t_m2m();
    mcyc = 0;
    send(16'h0004, 24'h000100, 24'h000200, 16'h0004, 8'h21);
    finish_op(4'h1, 8'h21);
    for (int i = 0; i < 4; i++)
      chk(i_bus.mem[9'h100 + i], 16'hA5A0 + i);
    chk(mcyc, 8);
    $display("test memory copy done");
  endtask
  task automatic t_fly();
    logic seen;
    seen = 1'b0;
    @(posedge mclk);
    waits <= 2'h2;
    mcyc = 0;
    send(16'h021D, 24'h000100, 24'h000000, 16'h0003, 8'h32);
    for (int i = 0; i < 20; i++)
    begin
      @(negedge mclk);
      seen = seen | (bus_request_n !== 1'b1);
    end
    chk(seen, 1'b0);
    @(posedge mclk);
    transfer_request <= 4'h4;
    finish_op(4'h1, 8'h32);
    chk(dev_cnt, 8'h03);
    chk(dev_last, 16'hA5A2);
    chk(mcyc, 9);
    @(posedge mclk);
    transfer_request <= 4'h0;
    waits <= 2'h0;
    $display("test fly-by done");
  endtask
  task automatic t_yield();
    send(16'h0004, 24'h000100, 24'h000300, 16'h0008, 8'h43);
    wait_master();
    chk(word_n, 1'b0);
    @(posedge mclk);
    yield <= 1'b1;
    repeat (5) @(negedge mclk);
    chk({bus_master, bus_request_n}, 2'h0);
    @(posedge mclk);
    yield <= 1'b0;
    finish_op(4'h1, 8'h43);
    for (int i = 0; i < 8; i++)
      chk(i_bus.mem[9'h180 + i], 16'hA5A0 + i);
    $display("test bus loss done");
  endtask
  task automatic t_abort();
    @(posedge mclk);
    dev_is_src <= 1'b1;
    transfer_request <= 4'h8;
    send(16'h00EE, 24'h000000, 24'h000380, 16'h0064, 8'h54);
    wait_master();
    repeat (4) @(negedge mclk);
    @(posedge mclk);
    hw_abort <= 1'b1;
    @(posedge mclk);
    hw_abort <= 1'b0;
    finish_op(4'h2, 8'h54);
    chk(i_bus.mem[9'h1C0], 16'hD003);
    @(posedge mclk);
    transfer_request <= 4'h0;
    dev_is_src <= 1'b0;
    $display("test abort done");
  endtask
  task automatic t_reject();
    send(16'h0004, 24'h000100, 24'h000500, 16'h0000, 8'h65);
    finish_op(4'h3, 8'h65);
    $display("test reject done");
  endtask
  // device drops its request on acknowledge and raises it again per operand
  task automatic t_single();
    logic [7:0] c0;
    int         n;
    c0 = dev_cnt;
    @(posedge mclk);
    waits <= 2'h2;
    send(16'h013D, 24'h000100, 24'h000000, 16'h0002, 8'h76);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge mclk);
      transfer_request <= 4'h2;
      n = 0;
      while (transfer_acknowledge_n !== 4'hD && n < 200)
      begin
        @(negedge mclk);
        n++;
      end
      if (n == 200)
        give_up();
      @(posedge mclk);
      transfer_request <= 4'h0;
      repeat (10) @(negedge mclk);
      chk(dev_cnt, 8'(c0 + k + 1));
      chk(bus_request_n, 1'b1);
    end
    finish_op(4'h1, 8'h76);
    @(posedge mclk);
    waits <= 2'h0;
    $display("test single request done");
  endtask
  task automatic t_swabort();
    logic seen;
    seen = 1'b0;
    send(16'h0001, 24'h000100, 24'h000000, 16'h0004, 8'h87);
    send(16'h1001, 24'h000000, 24'h000000, 16'h0004, 8'h87);
    repeat (2) @(posedge mclk);
    transfer_request <= 4'h1;
    for (int i = 0; i < 20; i++)
    begin
      @(negedge mclk);
      seen = seen | (bus_request_n !== 1'b1);
    end
    chk(seen, 1'b0);
    chk(host_interrupt, 1'b0);
    @(posedge mclk);
    transfer_request <= 4'h0;
    $display("test channel cancel done");
  endtask
  // ====================================
  // main sequence
  initial
  begin
    for (int i = 0; i < 16; i++)
      i_bus.mem[9'h080 + i] = 16'hA5A0 + 16'(i);
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    @(negedge mclk);
    t_reset();
    t_m2m();
    t_fly();
    t_yield();
    t_abort();
    t_single();
    t_swabort();
    t_reject();
    summarize();
  end
endmodule
